// ==== rtl/tlb_misc_control.sv ====
// translation control register with TLB read and write sequencing
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - read trigger loads page tag, tag, access
// R2 - read entry picked by line and set
// R3 - selector changes leave loaded values alone
// R4 - write-through enable gates array write
// R5 - enable set on violation or outer miss
// R6 - set select increments per array write
// R7 - up to 16 sets, zero upper bits
// R8 - process tag 8 to 14 bits
// R9 - software loads tag before each write
// R10 - array tag beats written tag on read
// R11 - double-miss flag follows each exception; a break exception leaves it unchanged
// R12 - bad-address flag for four address faults
// R13 - violation flag only for permission faults
// R14 - memory-side flag for data faults
// R15 - field access types, all reset zero
// R16 - unused tag kept zero by software
// R17 - access write with enable writes entry
// R18 - global entries skip tag in lookup
// R19 - bit placement of all fields
// R20 - read trigger self-clears, reads zero
module tlb_misc_control #(
    parameter int SET_BITS = 4,
    parameter int TAG_WIDTH = 14,
    parameter int LINE_BITS = 4,
    parameter int PAGE_BITS = 20,
    parameter int ACC_WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ctrlWrite,
    input wire logic [31:0] ctrlWdata,
    input wire logic accWrite,
    input wire logic [ACC_WIDTH-1:0] accWdata,
    input wire logic [PAGE_BITS-1:0] pageNumber,
    input wire logic excTaken,
    input wire tlb_misc_pkg::exc_kind_type excKind,
    input wire logic exception_handler_active,
    input wire logic arrayReadDone,
    input wire logic [PAGE_BITS-LINE_BITS-1:0] arrayTagData,
    input wire logic [TAG_WIDTH-1:0] arrayProcTag,
    input wire logic [ACC_WIDTH-1:0] arrayAccData,
    input wire logic arrayGlobal,
    output logic [31:0] ctrlRdata,
    output logic arrayReadReq,
    output logic arrayWriteReq,
    output logic [LINE_BITS-1:0] arrayLine,
    output logic [SET_BITS-1:0] arraySet,
    output logic [PAGE_BITS-1:0] arrayWrPage,
    output logic [TAG_WIDTH-1:0] arrayWrTag,
    output logic [ACC_WIDTH-1:0] arrayWrAcc,
    output logic [ACC_WIDTH-1:0] accData,
    output logic pageTagLoad,
    output logic [PAGE_BITS-LINE_BITS-1:0] pageTagData,
    output logic lookupUsesTag
);
    //////////////////////////////////////////////////////////////////////////
    // state
    logic [SET_BITS-1:0] setSel_r, setSel_nxt;
    logic writeEn_r, writeEn_nxt;
    logic [TAG_WIDTH-1:0] procTag_r, procTag_nxt;
    logic dblFlag_r, dblFlag_nxt, badFlag_r, badFlag_nxt;
    logic permFlag_r, permFlag_nxt, memFlag_r, memFlag_nxt;
    tlb_misc_pkg::rd_state_type rdState_r, rdState_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic readReq_r, readReq_nxt, writeReq_r, writeReq_nxt;
    logic [LINE_BITS-1:0] line_r, line_nxt;
    logic [SET_BITS-1:0] set_r, set_nxt;
    logic [PAGE_BITS-1:0] wrPage_r, wrPage_nxt;
    logic [TAG_WIDTH-1:0] wrTag_r, wrTag_nxt;
    logic [ACC_WIDTH-1:0] wrAcc_r, wrAcc_nxt, acc_r, acc_nxt;
    logic tagLoad_r, tagLoad_nxt;
    logic [PAGE_BITS-LINE_BITS-1:0] tagData_r, tagData_nxt;
    logic useTag_r, useTag_nxt;

    // true when a given exception kind relates to a data access
    function automatic logic isDataExc(input tlb_misc_pkg::exc_kind_type k);
        return (k == tlb_misc_pkg::EXC_MISS_DATA) || (k == tlb_misc_pkg::EXC_DBL_DATA) ||
            (k == tlb_misc_pkg::EXC_ACCESS_VIOLATION_FLAG_DATA) || (k == tlb_misc_pkg::EXC_MISALIGN_DATA) ||
            (k == tlb_misc_pkg::EXC_SUPV_DATA);
    endfunction : isDataExc

    // pack the readable view; read trigger always reads back zero
    function automatic logic [31:0] packView(input logic [SET_BITS-1:0] s, input logic we,
            input logic [TAG_WIDTH-1:0] t, input logic [3:0] f);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[tlb_misc_pkg::SET_LSB +: SET_BITS] = s; // R19
        v[tlb_misc_pkg::WE_BIT] = we;
        v[tlb_misc_pkg::TAG_LSB +: TAG_WIDTH] = t;
        v[tlb_misc_pkg::DBL_BIT:tlb_misc_pkg::MEM_BIT] = f;
        return v; // R20
    endfunction : packView

    //////////////////////////////////////////////////////////////////////////
    // next-state for register fields and array requests
    always_comb begin
        logic isMiss;
        logic isPerm;
        logic isDbl;
        isMiss = 1'b0;
        isPerm = 1'b0;
        isDbl = 1'b0;
        setSel_nxt = setSel_r;
        writeEn_nxt = writeEn_r;
        procTag_nxt = procTag_r;
        dblFlag_nxt = dblFlag_r;
        badFlag_nxt = badFlag_r;
        permFlag_nxt = permFlag_r;
        memFlag_nxt = memFlag_r;
        rdState_nxt = rdState_r;
        readReq_nxt = 1'b0;
        writeReq_nxt = 1'b0;
        line_nxt = line_r;
        set_nxt = set_r;
        wrPage_nxt = wrPage_r;
        wrTag_nxt = wrTag_r;
        wrAcc_nxt = wrAcc_r;
        acc_nxt = acc_r;
        tagLoad_nxt = 1'b0;
        tagData_nxt = tagData_r;
        useTag_nxt = useTag_r;
        // software writes: selector changes only store, they never refetch
        if (ctrlWrite) begin
            setSel_nxt = ctrlWdata[tlb_misc_pkg::SET_LSB +: SET_BITS]; // R3 R7
            writeEn_nxt = ctrlWdata[tlb_misc_pkg::WE_BIT];
            procTag_nxt = ctrlWdata[tlb_misc_pkg::TAG_LSB +: TAG_WIDTH]; // R8
            if (ctrlWdata[tlb_misc_pkg::RD_BIT]) begin
                readReq_nxt = 1'b1; // R1
                line_nxt = pageNumber[LINE_BITS-1:0]; // R2
                set_nxt = ctrlWdata[tlb_misc_pkg::SET_LSB +: SET_BITS]; // R2
                rdState_nxt = tlb_misc_pkg::RD_WAIT;
            end
        end
        // access register write, optionally written through to the array
        if (accWrite) begin
            acc_nxt = accWdata; // R4
            if (writeEn_r) begin
                writeReq_nxt = 1'b1; // R4 R17
                line_nxt = pageNumber[LINE_BITS-1:0];
                set_nxt = setSel_r;
                wrPage_nxt = pageNumber;
                wrTag_nxt = procTag_r;
                wrAcc_nxt = accWdata;
                setSel_nxt = SET_BITS'(setSel_r + 1'b1); // R6
            end
        end
        // array answer: returned tag wins over any same-cycle written tag
        if (rdState_r == tlb_misc_pkg::RD_WAIT && arrayReadDone) begin
            procTag_nxt = arrayProcTag; // R1 R10
            acc_nxt = arrayAccData;
            tagLoad_nxt = 1'b1;
            tagData_nxt = arrayTagData;
            useTag_nxt = ~arrayGlobal; // R18
            rdState_nxt = tlb_misc_pkg::RD_IDLE; // R20
        end
        // exception capture overrides software in the same cycle
        if (excTaken && excKind != tlb_misc_pkg::EXC_BREAK) begin
            isDbl = (excKind == tlb_misc_pkg::EXC_DBL_INST) ||
                (excKind == tlb_misc_pkg::EXC_DBL_DATA);
            isMiss = (excKind == tlb_misc_pkg::EXC_MISS_INST) ||
                (excKind == tlb_misc_pkg::EXC_MISS_DATA) || isDbl;
            isPerm = (excKind == tlb_misc_pkg::EXC_ACCESS_VIOLATION_FLAG_INST) ||
                (excKind == tlb_misc_pkg::EXC_ACCESS_VIOLATION_FLAG_DATA);
            dblFlag_nxt = isDbl; // R11
            badFlag_nxt = (excKind == tlb_misc_pkg::EXC_SUPV_INST) ||
                (excKind == tlb_misc_pkg::EXC_SUPV_DATA) ||
                (excKind == tlb_misc_pkg::EXC_MISALIGN_DATA) ||
                (excKind == tlb_misc_pkg::EXC_MISALIGN_DEST); // R12
            permFlag_nxt = isPerm; // R13
            memFlag_nxt = isDataExc(excKind); // R14
            if (isPerm || (isMiss && !exception_handler_active)) begin
                writeEn_nxt = 1'b1; // R5
            end
        end
        rdata_nxt = packView(setSel_nxt, writeEn_nxt, procTag_nxt,
            {dblFlag_nxt, badFlag_nxt, permFlag_nxt, memFlag_nxt});
    end

    // registers only; all fields clear on reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            setSel_r <= '0; // R15
            writeEn_r <= 1'b0;
            procTag_r <= '0;
            dblFlag_r <= 1'b0;
            badFlag_r <= 1'b0;
            permFlag_r <= 1'b0;
            memFlag_r <= 1'b0;
            rdState_r <= tlb_misc_pkg::RD_IDLE;
            rdata_r <= tlb_misc_pkg::CTRL_RESET;
            readReq_r <= 1'b0;
            writeReq_r <= 1'b0;
            line_r <= '0;
            set_r <= '0;
            wrPage_r <= '0;
            wrTag_r <= '0;
            wrAcc_r <= '0;
            acc_r <= '0;
            tagLoad_r <= 1'b0;
            tagData_r <= '0;
            useTag_r <= 1'b1;
        end else begin
            setSel_r <= setSel_nxt;
            writeEn_r <= writeEn_nxt;
            procTag_r <= procTag_nxt;
            dblFlag_r <= dblFlag_nxt;
            badFlag_r <= badFlag_nxt;
            permFlag_r <= permFlag_nxt;
            memFlag_r <= memFlag_nxt;
            rdState_r <= rdState_nxt;
            rdata_r <= rdata_nxt;
            readReq_r <= readReq_nxt;
            writeReq_r <= writeReq_nxt;
            line_r <= line_nxt;
            set_r <= set_nxt;
            wrPage_r <= wrPage_nxt;
            wrTag_r <= wrTag_nxt;
            wrAcc_r <= wrAcc_nxt;
            acc_r <= acc_nxt;
            tagLoad_r <= tagLoad_nxt;
            tagData_r <= tagData_nxt;
            useTag_r <= useTag_nxt;
        end
    end

    // outputs straight from flops
    assign ctrlRdata = rdata_r;
    assign arrayReadReq = readReq_r;
    assign arrayWriteReq = writeReq_r;
    assign arrayLine = line_r;
    assign arraySet = set_r;
    assign arrayWrPage = wrPage_r;
    assign arrayWrTag = wrTag_r;
    assign arrayWrAcc = wrAcc_r;
    assign accData = acc_r;
    assign pageTagLoad = tagLoad_r;
    assign pageTagData = tagData_r;
    assign lookupUsesTag = useTag_r;

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_write_through_req: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
        accWrite |=> arrayWriteReq == $past(writeEn_r))
        else $error("array write request does not follow enable");
    a_set_increment: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
        (accWrite && writeEn_r && !ctrlWrite) |=> setSel_r == $past(setSel_r) + 1'b1)
        else $error("set select did not advance on array write");
    // a write-through carries the live page number and process tag
    a_write_uses_tag: assert property (@(posedge core_clk) disable iff (!reset_n) // R17
        (accWrite && writeEn_r) |=>
        arrayWrTag == $past(procTag_r) && arrayWrPage == $past(pageNumber))
        else $error("array write fields wrong");
    a_access_violation_flag_sets_we: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
        (excTaken && (excKind == tlb_misc_pkg::EXC_ACCESS_VIOLATION_FLAG_DATA)) |=> writeEn_r)
        else $error("write enable not set on violation");
    a_miss_outer_we: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
        (excTaken && !exception_handler_active && (excKind == tlb_misc_pkg::EXC_MISS_INST ||
        excKind == tlb_misc_pkg::EXC_MISS_DATA)) |=> writeEn_r)
        else $error("write enable not set on outer miss");
    a_dbl_flag_track: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
        (excTaken && excKind != tlb_misc_pkg::EXC_BREAK) |=>
        dblFlag_r == ($past(excKind) inside {tlb_misc_pkg::EXC_DBL_INST,
        tlb_misc_pkg::EXC_DBL_DATA}))
        else $error("double-miss flag wrong");
    // exception flags are rewritten by every non-break exception
    a_bad_flag_track: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
        (excTaken && excKind != tlb_misc_pkg::EXC_BREAK) |=>
        badFlag_r == ($past(excKind) inside {tlb_misc_pkg::EXC_SUPV_INST,
        tlb_misc_pkg::EXC_SUPV_DATA, tlb_misc_pkg::EXC_MISALIGN_DATA,
        tlb_misc_pkg::EXC_MISALIGN_DEST}))
        else $error("bad-address flag wrong");
    a_break_keeps_flags: assert property (@(posedge core_clk) disable iff (!reset_n) // R11 R14
        (excTaken && excKind == tlb_misc_pkg::EXC_BREAK) |=>
        $stable({dblFlag_r, badFlag_r, permFlag_r, memFlag_r}))
        else $error("break exception changed the flags");
    a_access_violation_flag_flag_track: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
        (excTaken && excKind == tlb_misc_pkg::EXC_OTHER) |=> !permFlag_r && !badFlag_r)
        else $error("flags not cleared on other exception");
    a_data_side_flag: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
        (excTaken && excKind == tlb_misc_pkg::EXC_MISALIGN_DATA) |=> memFlag_r && badFlag_r)
        else $error("data-side flag missing");
    a_read_tag_wins: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
        (rdState_r == tlb_misc_pkg::RD_WAIT && arrayReadDone && !excTaken) |=>
        procTag_r == $past(arrayProcTag) && pageTagLoad)
        else $error("returned tag not stored");
    // a selector write alone must not reload the fetched entry
    a_select_no_refetch: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
        (ctrlWrite && !ctrlWdata[tlb_misc_pkg::RD_BIT] && !accWrite &&
        rdState_r == tlb_misc_pkg::RD_IDLE) |=> !pageTagLoad && $stable(accData))
        else $error("entry reloaded without a read");
    a_trigger_reads_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
        !ctrlRdata[tlb_misc_pkg::RD_BIT])
        else $error("read trigger visible");
    a_read_request: assert property (@(posedge core_clk) disable iff (!reset_n) // R1 R2
        (ctrlWrite && ctrlWdata[tlb_misc_pkg::RD_BIT]) |=>
        arrayReadReq && arraySet == $past(ctrlWdata[tlb_misc_pkg::SET_LSB +: SET_BITS]))
        else $error("read request missing");
endmodule : tlb_misc_control

// ==== rtl/tlb_misc_pkg.sv ====
// package: field layout, reset values and exception codes of the translation control register
package tlb_misc_pkg;
    localparam int SET_LSB = 20;
    localparam int SET_MSB = 23;
    localparam int RD_BIT = 19;
    localparam int WE_BIT = 18;
    localparam int TAG_LSB = 4;
    localparam int TAG_MSB = 17;
    localparam int DBL_BIT = 3;
    localparam int BAD_BIT = 2;
    localparam int ACCESS_VIOLATION_FLAG_BIT = 1;
    localparam int MEM_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int MAX_SETS_LOG2 = 4;
    localparam int MAX_TAG_WIDTH = 14;
    localparam int MIN_TAG_WIDTH = 8;
    // exception kinds reported by the core's exception logic
    typedef enum logic [3:0] {
        EXC_OTHER = 4'h0,
        EXC_MISS_INST = 4'h1,
        EXC_MISS_DATA = 4'h2,
        EXC_DBL_INST = 4'h3,
        EXC_DBL_DATA = 4'h4,
        EXC_ACCESS_VIOLATION_FLAG_INST = 4'h5,
        EXC_ACCESS_VIOLATION_FLAG_DATA = 4'h6,
        EXC_SUPV_INST = 4'h7,
        EXC_SUPV_DATA = 4'h8,
        EXC_MISALIGN_DATA = 4'h9,
        EXC_MISALIGN_DEST = 4'ha,
        EXC_BREAK = 4'hb
    } exc_kind_type;
    // read sequencer: idle, or waiting for the array to answer
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01
    } rd_state_type;
endpackage : tlb_misc_pkg

// ==== dv/tlb_array_model.sv ====
// behavioural TLB array answering the control block after a chosen latency
module tlb_array_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] latency,
    input wire logic arrayReadReq,
    input wire logic arrayWriteReq,
    input wire logic [3:0] arrayLine,
    input wire logic [3:0] arraySet,
    input wire logic [19:0] arrayWrPage,
    input wire logic [13:0] arrayWrTag,
    input wire logic [31:0] arrayWrAcc,
    output logic arrayReadDone,
    output logic [15:0] arrayTagData,
    output logic [13:0] arrayProcTag,
    output logic [31:0] arrayAccData,
    output logic arrayGlobal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [61:0] mem [256];
    logic [7:0] idx;
    int cnt;
    // an entry keeps page tag, process tag and access word; global is access bit 20
    always @(posedge core_clk) begin
        arrayReadDone <= 1'b0;
        if (arrayWriteReq) begin
            mem[{arraySet, arrayLine}] <= {arrayWrPage[19:4], arrayWrTag, arrayWrAcc};
        end
        if (!reset_n) begin
            cnt <= 0;
            {arrayTagData, arrayProcTag, arrayAccData, arrayGlobal} <= '0;
        end else if (arrayReadReq) begin
            idx <= {arraySet, arrayLine};
            cnt <= int'(latency) + 1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            arrayReadDone <= 1'b1;
            {arrayTagData, arrayProcTag, arrayAccData} <= mem[idx];
            arrayGlobal <= mem[idx][20];
        end else begin
            // no answer pending: lines scramble so stale data never passes for a reply
            {arrayTagData, arrayProcTag, arrayAccData} <= ~{arrayTagData, arrayProcTag, arrayAccData};
            arrayGlobal <= ~arrayGlobal;
        end
    end
endmodule : tlb_array_model

// ==== dv/tb_top.sv ====
// self-checking bench for the translation control register
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
        $display("[ERR] %0t got %h exp %h", $time, a, b); end end
    logic core_clk = 0, reset_n = 0, ctrlWrite = 0, accWrite = 0, excTaken = 0, ehActive = 0;
    logic [31:0] ctrlWdata = 0, accWdata = 0, ctrlRdata, arrayAccData, arrayWrAcc, accData;
    logic [19:0] pageNumber = 20'h1_2345, arrayWrPage;
    logic [15:0] arrayTagData, pageTagData;
    logic [13:0] arrayProcTag, arrayWrTag;
    logic [3:0] arrayLine, arraySet, latency = 0, flags = 0;
    logic arrayReadDone, arrayGlobal, arrayReadReq, arrayWriteReq, pageTagLoad, lookupUsesTag;
    tlb_misc_pkg::exc_kind_type excKind = tlb_misc_pkg::EXC_OTHER;
    int miscompares = 0, check_count = 0, cycles = 0;
    tlb_misc_control i_dut (.core_clk, .reset_n, .ctrlWrite, .ctrlWdata, .accWrite, .accWdata,
        .pageNumber, .excTaken, .excKind, .exception_handler_active(ehActive), .arrayReadDone,
        .arrayTagData, .arrayProcTag, .arrayAccData, .arrayGlobal, .ctrlRdata, .arrayReadReq,
        .arrayWriteReq, .arrayLine, .arraySet, .arrayWrPage, .arrayWrTag, .arrayWrAcc, .accData,
        .pageTagLoad, .pageTagData, .lookupUsesTag);
    tlb_array_model i_array (.core_clk, .reset_n, .latency, .arrayReadReq, .arrayWriteReq,
        .arrayLine, .arraySet, .arrayWrPage, .arrayWrTag, .arrayWrAcc, .arrayReadDone,
        .arrayTagData, .arrayProcTag, .arrayAccData, .arrayGlobal);
    always #4 core_clk = ~core_clk;
    // a hang ends the run as a failure
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // low nibble set on purpose: the flag bits must ignore writes
    task automatic ctrl(input logic [3:0] s, input logic we, rd, input logic [13:0] t);
        @(negedge core_clk);
        ctrlWrite = 1;
        ctrlWdata = {8'h00, s, rd, we, t, 4'hF};
        @(negedge core_clk);
        ctrlWrite = 0;
    endtask : ctrl
    task automatic t_reset();
        `CHK(ctrlRdata, 32'h0000_0000)
        `CHK(accData, 32'h0000_0000)
        `CHK(lookupUsesTag, 1'b1)
    endtask : t_reset
    task automatic t_fields();
        ctrl(4'h3, 1, 0, 14'h02AB);
        `CHK(ctrlRdata, 32'h0034_2AB0)
    endtask : t_fields
    // two write-throughs back to back, then one with the enable off
    task automatic t_write();
        @(negedge core_clk);
        accWrite = 1;
        accWdata = 32'h0010_0ABC;
        @(negedge core_clk);
        accWdata = 32'h0000_0DEF;
        `CHK(arrayWriteReq, 1'b1)
        `CHK({arraySet, arrayLine}, 8'h35)
        `CHK(arrayWrPage, 20'h1_2345)
        `CHK(arrayWrTag, 14'h02AB)
        `CHK(arrayWrAcc, 32'h0010_0ABC)
        @(negedge core_clk);
        accWrite = 0;
        `CHK(arraySet, 4'h4)
        `CHK(ctrlRdata[23:20], 4'h5)
        ctrl(4'h5, 0, 0, 14'h02AB);
        `CHK(accData, 32'h0000_0DEF)
        accWrite = 1;
        accWdata = 32'h0000_1234;
        @(negedge core_clk);
        accWrite = 0;
        `CHK(arrayWriteReq, 1'b0)
        `CHK(accData, 32'h0000_1234)
        `CHK(ctrlRdata[23:20], 4'h5)
    endtask : t_write
    task automatic t_read(input logic [3:0] s, lat, input logic [31:0] acc, input logic g);
        logic [31:0] old;
        latency = lat;
        old = accData;
        ctrl(s, 0, 1, 14'h0055);
        `CHK(arrayReadReq, 1'b1)
        `CHK({arraySet, arrayLine}, {s, 4'h5})
        `CHK(ctrlRdata[19], 1'b0)
        pageNumber = 20'h0_0000;
        `CHK(accData, old)
        for (int i = 0; i < 20 && pageTagLoad !== 1'b1; i++) @(negedge core_clk);
        `CHK(pageTagLoad, 1'b1)
        `CHK(pageTagData, 16'h1234)
        `CHK(ctrlRdata[17:4], 14'h02AB)
        `CHK(accData, acc)
        `CHK(lookupUsesTag, ~g)
        pageNumber = 20'h1_2345;
    endtask : t_read
    task automatic exc(input tlb_misc_pkg::exc_kind_type k, input logic eh,
            input logic [3:0] f, input logic we);
        ctrl(4'h0, 0, 0, 14'h0000);
        `CHK(ctrlRdata[3:0], flags)
        excTaken = 1;
        excKind = k;
        ehActive = eh;
        @(negedge core_clk);
        excTaken = 0;
        `CHK(ctrlRdata[3:0], f)
        `CHK(ctrlRdata[18], we)
        flags = f;
    endtask : exc
    // every exception kind, flags as {double, bad, violation, data side}
    task automatic t_exc();
        exc(tlb_misc_pkg::EXC_ACCESS_VIOLATION_FLAG_DATA, 1, 4'b0011, 1);
        exc(tlb_misc_pkg::EXC_BREAK, 0, flags, 0);
        exc(tlb_misc_pkg::EXC_MISS_INST, 0, 4'b0000, 1);
        exc(tlb_misc_pkg::EXC_MISS_DATA, 0, 4'b0001, 1);
        exc(tlb_misc_pkg::EXC_MISS_DATA, 1, 4'b0001, 0);
        exc(tlb_misc_pkg::EXC_DBL_INST, 1, 4'b1000, 0);
        exc(tlb_misc_pkg::EXC_DBL_DATA, 1, 4'b1001, 0);
        exc(tlb_misc_pkg::EXC_ACCESS_VIOLATION_FLAG_INST, 1, 4'b0010, 1);
        exc(tlb_misc_pkg::EXC_SUPV_INST, 0, 4'b0100, 0);
        exc(tlb_misc_pkg::EXC_SUPV_DATA, 0, 4'b0101, 0);
        exc(tlb_misc_pkg::EXC_MISALIGN_DATA, 0, 4'b0101, 0);
        exc(tlb_misc_pkg::EXC_MISALIGN_DEST, 0, 4'b0100, 0);
        exc(tlb_misc_pkg::EXC_OTHER, 0, 4'b0000, 0);
    endtask : t_exc
    initial begin
        repeat (2) @(negedge core_clk);
        reset_n = 1;
        t_reset();
        t_fields();
        t_write();
        t_read(4'h4, 4'h6, 32'h0000_0DEF, 1'b0);
        t_read(4'h3, 4'h0, 32'h0010_0ABC, 1'b1);
        t_exc();
        results();
    end
endmodule : tb_top
